// file: pkg/dsa_defs.svh
// Address map, step sizes and field positions of the data space access unit
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH

`define DSA_AW 16
`define DSA_DW 16
`define DSA_BW 8
`define DSA_NEAR_W 13
`define DSA_PSV_BIT 15
`define DSA_BYTE_SEL 0
`define DSA_SIGN_BIT 7
`define DSA_CTRL_END 16'h07ff
`define DSA_NEAR_END 16'h1fff
`define DSA_X_BASE 16'h0800
`define DSA_Y_BASE 16'h1800
`define DSA_DMA_BASE 16'h2000
`define DSA_RAM_END 16'h27ff
`define DSA_RAM_WORDS 4096
`define DSA_IDX_W 12
`define DSA_DMA_IDX_W 10
`define DSA_DMA_IDX 12'hc00
`define DSA_BYTE_STEP 16'h0001
`define DSA_WORD_STEP 16'h0002
`define DSA_ONE 16'h0001
`define DSA_ZERO_BYTE 8'h00
`define DSA_ZERO_WORD 16'h0000

`endif

// file: pkg/dsa_pkg.sv
// Types shared by the data space access unit
`include "dsa_defs.svh"
package dsa_pkg;

	// Address generator update modes
	typedef enum logic [2:0] {
		DSA_IND,
		DSA_POST_INC,
		DSA_POST_DEC,
		DSA_PRE_INC,
		DSA_PRE_DEC,
		DSA_NEAR_ABS,
		DSA_FULL_ABS
	} dsa_agu_mode_t;

	// Working register byte operations
	typedef enum logic [1:0] {
		DSA_LOAD_WORD,
		DSA_LOAD_BYTE,
		DSA_BYTE_SIGN_WIDEN_OP,
		DSA_UPPER_BYTE_CLEAR_OP
	} dsa_wop_t;

	typedef struct packed {
		logic [`DSA_DW-1:0] x_rd_data;
		logic x_rd_valid;
		logic [`DSA_DW-1:0] y_rd_data;
		logic y_rd_valid;
		logic addr_trap;
		logic [`DSA_DW-1:0] dma_rdata;
		logic dma_collide;
		logic [`DSA_AW-1:0] ax_ea;
		logic [`DSA_AW-1:0] ax_ptr;
		logic ax_valid;
		logic [`DSA_AW-1:0] ay_ea;
		logic [`DSA_AW-1:0] ay_ptr;
		logic ay_valid;
		logic [`DSA_DW-1:0] wr_result;
		logic wr_valid;
		logic ctrl_wr_en;
		logic [`DSA_AW-1:0] ctrl_wr_addr;
		logic [`DSA_DW-1:0] ctrl_wr_data;
		logic ctrl_wr_lo;
		logic ctrl_wr_hi;
	} dsa_state_t;

endpackage

// file: logic/dsa_unit.sv
// Data space access unit: address generators, byte lanes, traps, shared RAM
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dsa_unit (
	input wire logic clk_sys,
	input wire logic reset,
	// X address generator
	input wire logic ax_req,
	input wire dsa_pkg::dsa_agu_mode_t ax_mode,
	input wire logic [`DSA_AW-1:0] ax_source_pointer_register,
	input wire logic [`DSA_AW-1:0] ax_abs,
	input wire logic ax_byte,
	input wire logic ax_write,
	input wire logic ax_bitrev_en,
	input wire logic [`DSA_AW-1:0] ax_bitrev_mod,
	input wire logic ax_mod_en,
	input wire logic [`DSA_AW-1:0] ax_mod_start,
	input wire logic [`DSA_AW-1:0] ax_mod_end,
	output logic [`DSA_AW-1:0] ax_byte_pointer_value,
	output logic [`DSA_AW-1:0] ax_ptr_next,
	output logic ax_valid,
	// Y address generator
	input wire logic ay_req,
	input wire dsa_pkg::dsa_agu_mode_t ay_mode,
	input wire logic [`DSA_AW-1:0] ay_source_pointer_register,
	input wire logic ay_byte,
	input wire logic ay_mod_en,
	input wire logic [`DSA_AW-1:0] ay_mod_start,
	input wire logic [`DSA_AW-1:0] ay_mod_end,
	output logic [`DSA_AW-1:0] ay_byte_pointer_value,
	output logic [`DSA_AW-1:0] ay_ptr_next,
	output logic ay_valid,
	// X read bus (unified space)
	input wire logic x_rd_en,
	input wire logic [`DSA_AW-1:0] x_rd_addr,
	input wire logic x_rd_byte,
	output logic [`DSA_DW-1:0] x_rd_data,
	output logic x_rd_valid,
	// Y read bus
	input wire logic y_rd_en,
	input wire logic [`DSA_AW-1:0] y_rd_addr,
	output logic [`DSA_DW-1:0] y_rd_data,
	output logic y_rd_valid,
	// X write bus (unified space)
	input wire logic x_wr_en,
	input wire logic [`DSA_AW-1:0] x_wr_addr,
	input wire logic x_wr_byte,
	input wire logic [`DSA_DW-1:0] x_wr_data,
	output logic addr_trap,
	// Control register region
	input wire logic ctrl_rd_hit,
	input wire logic [`DSA_DW-1:0] ctrl_rd_data,
	output logic ctrl_wr_en,
	output logic [`DSA_AW-1:0] ctrl_wr_addr,
	output logic [`DSA_DW-1:0] ctrl_wr_data,
	output logic ctrl_wr_lo,
	output logic ctrl_wr_hi,
	// Program space window
	output logic psv_rd_en,
	input wire logic [`DSA_DW-1:0] psv_rd_data,
	// DMA port into shared RAM
	input wire logic dma_en,
	input wire logic dma_we,
	input wire logic [`DSA_DMA_IDX_W-1:0] dma_addr,
	input wire logic [`DSA_DW-1:0] dma_wdata,
	output logic [`DSA_DW-1:0] dma_rdata,
	output logic dma_collide,
	// Working register byte operations
	input wire logic wr_req,
	input wire dsa_pkg::dsa_wop_t wr_op,
	input wire logic [`DSA_DW-1:0] wr_cur,
	input wire logic [`DSA_DW-1:0] wr_src,
	output logic [`DSA_DW-1:0] wr_result,
	output logic wr_valid
);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic in_ram(input logic [`DSA_AW-1:0] a);
		return (a >= `DSA_X_BASE) && (a <= `DSA_RAM_END);
	endfunction

	function automatic logic in_y(input logic [`DSA_AW-1:0] a);
		return (a >= `DSA_Y_BASE) && (a <= `DSA_RAM_END);
	endfunction

	function automatic logic in_ctrl(input logic [`DSA_AW-1:0] a);
		return (a[`DSA_PSV_BIT] == 1'b0) && (a <= `DSA_CTRL_END);
	endfunction

	function automatic logic [`DSA_IDX_W-1:0] ram_idx(input logic [`DSA_AW-1:0] a);
		logic [`DSA_AW-1:0] d;
		d = a - `DSA_X_BASE;
		return d[`DSA_IDX_W:1];
	endfunction

	function automatic logic [`DSA_AW-1:0] rev16(input logic [`DSA_AW-1:0] a);
		logic [`DSA_AW-1:0] r;
		for (int i = 0; i < `DSA_AW; i++) begin
			r[i] = a[`DSA_AW-1-i];
		end
		return r;
	endfunction

	// Pointer update with modulo wrap or reversed-carry stepping
	function automatic logic [`DSA_AW-1:0] ptr_upd(input logic [`DSA_AW-1:0] p,
			input logic inc, input logic byte_op, input logic brev,
			input logic [`DSA_AW-1:0] bmod, input logic men,
			input logic [`DSA_AW-1:0] ms, input logic [`DSA_AW-1:0] me);
		logic [`DSA_AW-1:0] step;
		logic [`DSA_AW-1:0] len;
		logic [`DSA_AW-1:0] s;
		step = byte_op ? `DSA_BYTE_STEP : `DSA_WORD_STEP;
		len = me - ms + `DSA_ONE;
		if (brev && inc) begin
			s = rev16(rev16(p) + rev16(bmod));
		end else if (inc) begin
			s = p + step;
			if (men && (s > me)) begin
				s = s - len;
			end
		end else begin
			s = p - step;
			if (men && (p < ms + step)) begin
				s = s + len;
			end
		end
		return s;
	endfunction

	// Returns {effective address, next pointer}
	function automatic logic [2*`DSA_AW-1:0] address_generator(input dsa_pkg::dsa_agu_mode_t m,
			input logic [`DSA_AW-1:0] p, input logic [`DSA_AW-1:0] ab,
			input logic byte_op, input logic brev, input logic [`DSA_AW-1:0] bmod,
			input logic men, input logic [`DSA_AW-1:0] ms, input logic [`DSA_AW-1:0] me);
		logic [`DSA_AW-1:0] up;
		logic [`DSA_AW-1:0] dn;
		logic [`DSA_AW-1:0] nr;
		up = ptr_upd(p, 1'b1, byte_op, brev, bmod, men, ms, me);
		dn = ptr_upd(p, 1'b0, byte_op, brev, bmod, men, ms, me);
		nr = {{(`DSA_AW-`DSA_NEAR_W){1'b0}}, ab[`DSA_NEAR_W-1:0]};
		case (m)
			dsa_pkg::DSA_POST_INC: return {p, up};
			dsa_pkg::DSA_POST_DEC: return {p, dn};
			dsa_pkg::DSA_PRE_INC: return {up, up};
			dsa_pkg::DSA_PRE_DEC: return {dn, dn};
			dsa_pkg::DSA_NEAR_ABS: return {nr, p};
			dsa_pkg::DSA_FULL_ABS: return {ab, p};
			default: return {p, p};
		endcase
	endfunction

	// ********************************
	// State and memory
	// ********************************
	dsa_pkg::dsa_state_t st;
	dsa_pkg::dsa_state_t next_st;
	logic [`DSA_BW-1:0] ram_lo [`DSA_RAM_WORDS];
	logic [`DSA_BW-1:0] ram_hi [`DSA_RAM_WORDS];

	logic rd_odd;
	logic wr_odd;
	logic [`DSA_IDX_W-1:0] x_ridx;
	logic [`DSA_IDX_W-1:0] y_ridx;
	logic [`DSA_IDX_W-1:0] x_widx;
	logic [`DSA_IDX_W-1:0] d_idx;
	logic core_ram_wr;
	logic core_wr_lo;
	logic core_wr_hi;
	logic dma_wr_lo;
	logic dma_wr_hi;
	logic [`DSA_DW-1:0] x_word;
	logic [`DSA_BW-1:0] wr_byte_val;

	assign rd_odd = x_rd_en && !x_rd_byte && x_rd_addr[`DSA_BYTE_SEL];
	assign wr_odd = x_wr_en && !x_wr_byte && x_wr_addr[`DSA_BYTE_SEL];
	assign x_ridx = ram_idx(x_rd_addr);
	assign y_ridx = ram_idx(y_rd_addr);
	assign x_widx = ram_idx(x_wr_addr);
	assign d_idx = `DSA_DMA_IDX + {{(`DSA_IDX_W-`DSA_DMA_IDX_W){1'b0}}, dma_addr};
	assign core_ram_wr = x_wr_en && !wr_odd && in_ram(x_wr_addr);
	assign core_wr_lo = core_ram_wr && (!x_wr_byte || !x_wr_addr[`DSA_BYTE_SEL]);
	assign core_wr_hi = core_ram_wr && (!x_wr_byte || x_wr_addr[`DSA_BYTE_SEL]);
	// Lane-wise precedence: only the lanes the core writes are withheld
	assign dma_wr_lo = dma_en && dma_we && !(core_wr_lo && (x_widx == d_idx));
	assign dma_wr_hi = dma_en && dma_we && !(core_wr_hi && (x_widx == d_idx));
	assign wr_byte_val = x_wr_data[`DSA_BW-1:0];
	assign psv_rd_en = x_rd_en && x_rd_addr[`DSA_PSV_BIT];

	// Core and DMA ports both write the array in one cycle; a lane both hit at one index keeps the core data
	always_ff @(posedge clk_sys) begin
		if (dma_wr_lo) begin
			ram_lo[d_idx] <= dma_wdata[`DSA_BW-1:0];
		end
		if (dma_wr_hi) begin
			ram_hi[d_idx] <= dma_wdata[`DSA_DW-1:`DSA_BW];
		end
		if (core_wr_lo) begin
			ram_lo[x_widx] <= x_wr_byte ? wr_byte_val : x_wr_data[`DSA_BW-1:0];
		end
		if (core_wr_hi) begin
			ram_hi[x_widx] <= x_wr_byte ? wr_byte_val : x_wr_data[`DSA_DW-1:`DSA_BW];
		end
	end

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		next_st = st;
		next_st.x_rd_valid = x_rd_en;
		next_st.y_rd_valid = y_rd_en;
		next_st.ax_valid = ax_req;
		next_st.ay_valid = ay_req;
		next_st.wr_valid = wr_req;
		next_st.addr_trap = rd_odd || wr_odd;
		next_st.ctrl_wr_en = 1'b0;
		next_st.ctrl_wr_lo = 1'b0;
		next_st.ctrl_wr_hi = 1'b0;
		next_st.dma_collide = dma_en && dma_we && (!dma_wr_lo || !dma_wr_hi);
		x_word = `DSA_ZERO_WORD;
		if (x_rd_addr[`DSA_PSV_BIT]) begin
			x_word = psv_rd_data;
		end else if (in_ctrl(x_rd_addr)) begin
			x_word = ctrl_rd_hit ? ctrl_rd_data : `DSA_ZERO_WORD;
		end else if (in_ram(x_rd_addr)) begin
			x_word = {ram_hi[x_ridx], ram_lo[x_ridx]};
		end
		if (x_rd_en) begin
			if (x_rd_byte) begin
				next_st.x_rd_data = {`DSA_ZERO_BYTE, x_rd_addr[`DSA_BYTE_SEL] ?
					x_word[`DSA_DW-1:`DSA_BW] : x_word[`DSA_BW-1:0]};
			end else begin
				next_st.x_rd_data = x_word;
			end
		end
		if (y_rd_en) begin
			next_st.y_rd_data = in_y(y_rd_addr) ?
				{ram_hi[y_ridx], ram_lo[y_ridx]} : `DSA_ZERO_WORD;
		end
		if (x_wr_en && !wr_odd && in_ctrl(x_wr_addr)) begin
			next_st.ctrl_wr_en = 1'b1;
			next_st.ctrl_wr_addr = x_wr_addr;
			next_st.ctrl_wr_data = x_wr_byte ? {wr_byte_val, wr_byte_val} : x_wr_data;
			next_st.ctrl_wr_lo = !x_wr_byte || !x_wr_addr[`DSA_BYTE_SEL];
			next_st.ctrl_wr_hi = !x_wr_byte || x_wr_addr[`DSA_BYTE_SEL];
		end
		if (dma_en) begin
			next_st.dma_rdata = {ram_hi[d_idx], ram_lo[d_idx]};
		end
		if (ax_req) begin
			{next_st.ax_ea, next_st.ax_ptr} = address_generator(ax_mode, ax_source_pointer_register,
				ax_abs, ax_byte, ax_bitrev_en && ax_write, ax_bitrev_mod,
				ax_mod_en, ax_mod_start, ax_mod_end);
		end
		if (ay_req) begin
			{next_st.ay_ea, next_st.ay_ptr} = address_generator(ay_mode, ay_source_pointer_register,
				`DSA_ZERO_WORD, ay_byte, 1'b0, `DSA_ZERO_WORD,
				ay_mod_en, ay_mod_start, ay_mod_end);
		end
		if (wr_req) begin
			case (wr_op)
				dsa_pkg::DSA_LOAD_BYTE:
					next_st.wr_result = {wr_cur[`DSA_DW-1:`DSA_BW], wr_src[`DSA_BW-1:0]};
				dsa_pkg::DSA_BYTE_SIGN_WIDEN_OP:
					next_st.wr_result = {{`DSA_BW{wr_src[`DSA_SIGN_BIT]}},
						wr_src[`DSA_BW-1:0]};
				dsa_pkg::DSA_UPPER_BYTE_CLEAR_OP:
					next_st.wr_result = {`DSA_ZERO_BYTE, wr_src[`DSA_BW-1:0]};
				default:
					next_st.wr_result = wr_src;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign x_rd_data = st.x_rd_data;
	assign x_rd_valid = st.x_rd_valid;
	assign y_rd_data = st.y_rd_data;
	assign y_rd_valid = st.y_rd_valid;
	assign addr_trap = st.addr_trap;
	assign dma_rdata = st.dma_rdata;
	assign dma_collide = st.dma_collide;
	assign ax_byte_pointer_value = st.ax_ea;
	assign ax_ptr_next = st.ax_ptr;
	assign ax_valid = st.ax_valid;
	assign ay_byte_pointer_value = st.ay_ea;
	assign ay_ptr_next = st.ay_ptr;
	assign ay_valid = st.ay_valid;
	assign wr_result = st.wr_result;
	assign wr_valid = st.wr_valid;
	assign ctrl_wr_en = st.ctrl_wr_en;
	assign ctrl_wr_addr = st.ctrl_wr_addr;
	assign ctrl_wr_data = st.ctrl_wr_data;
	assign ctrl_wr_lo = st.ctrl_wr_lo;
	assign ctrl_wr_hi = st.ctrl_wr_hi;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_BYTE_STEP: assert property (
		ax_req && ax_mode == dsa_pkg::DSA_POST_INC && ax_byte && !ax_mod_en && !ax_bitrev_en
		|=> ax_ptr_next == $past(ax_source_pointer_register) + `DSA_BYTE_STEP)
		else $error("byte post-increment did not step by one");
	AST_WORD_STEP: assert property (
		ax_req && ax_mode == dsa_pkg::DSA_POST_INC && !ax_byte && !ax_mod_en
		&& !(ax_bitrev_en && ax_write)
		|=> ax_ptr_next == $past(ax_source_pointer_register) + `DSA_WORD_STEP)
		else $error("word post-increment did not step by two");
	AST_BYTE_READ_LOW: assert property (
		x_rd_en && x_rd_byte |=> x_rd_valid && x_rd_data[`DSA_DW-1:`DSA_BW] == `DSA_ZERO_BYTE)
		else $error("byte read left upper byte set");
	AST_TRAP_CAUSE: assert property (
		addr_trap |-> $past(rd_odd || wr_odd))
		else $error("trap without misaligned access");
	AST_TRAP_RAISED: assert property (
		(rd_odd || wr_odd) |=> addr_trap ##1 (!addr_trap || $past(rd_odd || wr_odd)))
		else $error("misaligned access did not trap");
	AST_STORE_DROPPED: assert property (
		wr_odd && in_ctrl(x_wr_addr) |=> !ctrl_wr_en)
		else $error("misaligned store reached control region");
	AST_BYTE_LOAD: assert property (
		wr_req && wr_op == dsa_pkg::DSA_LOAD_BYTE
		|=> wr_result[`DSA_DW-1:`DSA_BW] == $past(wr_cur[`DSA_DW-1:`DSA_BW]))
		else $error("byte load changed upper byte");
	AST_SIGN_WIDEN: assert property (
		wr_req && wr_op == dsa_pkg::DSA_BYTE_SIGN_WIDEN_OP
		|=> wr_result == {{`DSA_BW{$past(wr_src[`DSA_SIGN_BIT])}}, $past(wr_src[`DSA_BW-1:0])})
		else $error("sign widen wrong");
	AST_UPPER_CLEAR: assert property (
		wr_req && wr_op == dsa_pkg::DSA_UPPER_BYTE_CLEAR_OP
		|=> wr_result[`DSA_DW-1:`DSA_BW] == `DSA_ZERO_BYTE)
		else $error("upper byte clear left bits set");
	AST_CTRL_ZERO: assert property (
		x_rd_en && !x_rd_byte && in_ctrl(x_rd_addr) && !ctrl_rd_hit |=> x_rd_data == `DSA_ZERO_WORD)
		else $error("unused control address read nonzero");
	AST_NEAR_RANGE: assert property (
		ax_req && ax_mode == dsa_pkg::DSA_NEAR_ABS |=> ax_byte_pointer_value <= `DSA_NEAR_END)
		else $error("near address outside near region");
	AST_PSV_ROUTE: assert property (
		x_rd_en && !x_rd_byte && x_rd_addr[`DSA_PSV_BIT]
		|-> psv_rd_en ##1 x_rd_data == $past(psv_rd_data))
		else $error("upper half read not routed to program window");
	AST_CORE_WINS: assert property (
		dma_en && dma_we && core_wr_lo && core_wr_hi && x_widx == d_idx |=> dma_collide)
		else $error("collision not resolved for core");

	COV_MISALIGN_READ: cover property (rd_odd ##1 addr_trap);
	COV_DUAL_READ: cover property (x_rd_en && y_rd_en && in_y(y_rd_addr));
	COV_COLLIDE: cover property (dma_collide);
	COV_BITREV: cover property (ax_req && ax_write && ax_bitrev_en);

endmodule

// file: test/dsa_far_model.sv
// Far-side model: control register file and program space window
`timescale 1ns/1ps
module dsa_far_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] x_rd_addr,
	input wire logic ctrl_wr_en,
	input wire logic [15:0] ctrl_wr_addr,
	input wire logic [15:0] ctrl_wr_data,
	input wire logic ctrl_wr_lo,
	input wire logic ctrl_wr_hi,
	output logic ctrl_rd_hit,
	output logic [15:0] ctrl_rd_data,
	output logic [15:0] psv_rd_data
);
	logic [15:0] regs [4];
	logic wr_hit;

	assign wr_hit = ctrl_wr_en && (ctrl_wr_addr[15:3] == 13'h0004);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				regs[i] <= 16'h0000;
			end
		end else if (wr_hit) begin
			if (ctrl_wr_lo) begin
				regs[ctrl_wr_addr[2:1]][7:0] <= ctrl_wr_data[7:0];
			end
			if (ctrl_wr_hi) begin
				regs[ctrl_wr_addr[2:1]][15:8] <= ctrl_wr_data[15:8];
			end
		end
	end

	// Only four words exist; elsewhere the data lines carry junk
	assign ctrl_rd_hit = x_rd_addr[15:3] == 13'h0004;
	assign ctrl_rd_data = ctrl_rd_hit ? regs[x_rd_addr[2:1]] : 16'ha5a5;
	assign psv_rd_data = {x_rd_addr[7:0], ~x_rd_addr[7:0]};
endmodule

// file: test/data_space_access_unit_tb_top.sv
// Self-checking bench for the data space access unit
`timescale 1ns/1ps
module data_space_access_unit_tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys, reset;
	logic ax_req, ax_byte, ax_write, ax_bitrev_en, ax_mod_en, ax_valid;
	logic ay_req, ay_byte, ay_mod_en, ay_valid;
	logic [15:0] ax_source_pointer_register, ax_abs, ax_bitrev_mod, ax_mod_start, ax_mod_end;
	logic [15:0] ax_byte_pointer_value, ax_ptr_next, ay_byte_pointer_value, ay_ptr_next;
	logic [15:0] ay_source_pointer_register, ay_mod_start, ay_mod_end;
	dsa_pkg::dsa_agu_mode_t ax_mode, ay_mode;
	logic x_rd_en, x_rd_byte, x_rd_valid, y_rd_en, y_rd_valid, x_wr_en, x_wr_byte, addr_trap;
	logic [15:0] x_rd_addr, x_rd_data, y_rd_addr, y_rd_data, x_wr_addr, x_wr_data;
	logic ctrl_rd_hit, ctrl_wr_en, ctrl_wr_lo, ctrl_wr_hi, psv_rd_en;
	logic [15:0] ctrl_rd_data, ctrl_wr_addr, ctrl_wr_data, psv_rd_data;
	logic dma_en, dma_we, dma_collide, wr_req, wr_valid;
	logic [9:0] dma_addr;
	logic [15:0] dma_wdata, dma_rdata, wr_cur, wr_src, wr_result, d, q;
	dsa_pkg::dsa_wop_t wr_op;
	logic t;
	int n_mismatch = 0;
	int cmp_count = 0;

	dsa_unit u_dut (.*);
	dsa_far_model u_far (.*);

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Checking and bus helpers
	// ****************************************
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic rd(input logic [15:0] a, input logic b);
		@(negedge clk_sys);
		x_rd_en = 1'h1;
		x_rd_addr = a;
		x_rd_byte = b;
		@(negedge clk_sys);
		chk("psv_rd_en", a[15], psv_rd_en);
		x_rd_en = 1'h0;
		chk("x_rd_valid", 1'h1, x_rd_valid);
		d = x_rd_data;
		t = addr_trap;
	endtask

	task automatic yrd(input logic [15:0] a, input logic [15:0] e);
		@(negedge clk_sys);
		y_rd_en = 1'h1;
		y_rd_addr = a;
		@(negedge clk_sys);
		y_rd_en = 1'h0;
		chk("y_rd_valid", 1'h1, y_rd_valid);
		chk("y_rd_data", e, y_rd_data);
	endtask

	task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] v);
		@(negedge clk_sys);
		x_wr_en = 1'h1;
		x_wr_addr = a;
		x_wr_byte = b;
		x_wr_data = v;
		@(negedge clk_sys);
		x_wr_en = 1'h0;
		t = addr_trap;
	endtask

	task automatic dma(input logic w, input logic [9:0] i, input logic [15:0] v);
		@(negedge clk_sys);
		dma_en = 1'h1;
		dma_we = w;
		dma_addr = i;
		dma_wdata = v;
		@(negedge clk_sys);
		dma_en = 1'h0;
		q = dma_rdata;
	endtask

	task automatic col(input logic [15:0] a, input logic b, input logic [15:0] v,
			input logic [9:0] i, input logic [15:0] w);
		@(negedge clk_sys);
		x_wr_en = 1'h1;
		x_wr_addr = a;
		x_wr_byte = b;
		x_wr_data = v;
		dma_en = 1'h1;
		dma_we = 1'h1;
		dma_addr = i;
		dma_wdata = w;
		@(negedge clk_sys);
		x_wr_en = 1'h0;
		dma_en = 1'h0;
		chk("dma_collide", 1'h1, dma_collide);
	endtask

	task automatic agux(input dsa_pkg::dsa_agu_mode_t m, input logic b, input logic w,
			input logic [15:0] p, input logic [15:0] ea, input logic [15:0] np);
		@(negedge clk_sys);
		ax_req = 1'h1;
		ax_mode = m;
		ax_byte = b;
		ax_write = w;
		ax_source_pointer_register = p;
		ax_abs = p;
		@(negedge clk_sys);
		ax_req = 1'h0;
		chk("ax_valid", 1'h1, ax_valid);
		chk("ax_ea", ea, ax_byte_pointer_value);
		chk("ax_ptr", np, ax_ptr_next);
	endtask

	task automatic ayg(input dsa_pkg::dsa_agu_mode_t m, input logic b,
			input logic [15:0] p, input logic [15:0] ea, input logic [15:0] np);
		@(negedge clk_sys);
		ay_req = 1'h1;
		ay_mode = m;
		ay_byte = b;
		ay_source_pointer_register = p;
		@(negedge clk_sys);
		ay_req = 1'h0;
		chk("ay_valid", 1'h1, ay_valid);
		chk("ay_ea", ea, ay_byte_pointer_value);
		chk("ay_ptr", np, ay_ptr_next);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_agu;
		agux(dsa_pkg::DSA_POST_INC, 1'h1, 1'h0, 16'h0900, 16'h0900, 16'h0901);
		agux(dsa_pkg::DSA_POST_INC, 1'h0, 1'h0, 16'h0900, 16'h0900, 16'h0902);
		agux(dsa_pkg::DSA_PRE_DEC, 1'h0, 1'h0, 16'h0900, 16'h08fe, 16'h08fe);
		agux(dsa_pkg::DSA_NEAR_ABS, 1'h0, 1'h0, 16'hffff, 16'h1fff, 16'hffff);
		agux(dsa_pkg::DSA_FULL_ABS, 1'h0, 1'h0, 16'habcd, 16'habcd, 16'habcd);
		agux(dsa_pkg::DSA_IND, 1'h0, 1'h0, 16'h4321, 16'h4321, 16'h4321);
		ax_bitrev_en = 1'h1;
		agux(dsa_pkg::DSA_POST_INC, 1'h0, 1'h0, 16'h0900, 16'h0900, 16'h0902);
		agux(dsa_pkg::DSA_POST_INC, 1'h0, 1'h1, 16'h0900, 16'h0900, 16'h0908);
		ax_bitrev_en = 1'h0;
		ax_mod_en = 1'h1;
		agux(dsa_pkg::DSA_POST_INC, 1'h0, 1'h0, 16'h090e, 16'h090e, 16'h0900);
		ax_mod_en = 1'h0;
		ayg(dsa_pkg::DSA_POST_INC, 1'h1, 16'h1850, 16'h1850, 16'h1851);
		ay_mod_en = 1'h1;
		ayg(dsa_pkg::DSA_POST_DEC, 1'h0, 16'h1800, 16'h1800, 16'h180e);
		ay_mod_en = 1'h0;
	endtask

	task automatic t_mem;
		wr(16'h0900, 1'h0, 16'h1234);
		chk("ctrl_wr_en", 1'h0, ctrl_wr_en);
		wr(16'h0901, 1'h0, 16'h5555);
		chk("trap_wr", 1'h1, t);
		rd(16'h0900, 1'h0);
		chk("drop_wr", 16'h1234, d);
		chk("no_trap", 1'h0, t);
		rd(16'h0901, 1'h0);
		chk("trap_rd", 1'h1, t);
		chk("mis_rd", 16'h1234, d);
		rd(16'h0901, 1'h1);
		chk("byte_hi", 16'h0012, d);
		rd(16'h0900, 1'h1);
		chk("byte_lo", 16'h0034, d);
		wr(16'h0901, 1'h1, 16'h00ee);
		chk("no_trap", 1'h0, t);
		rd(16'h0900, 1'h0);
		chk("lane_hi", 16'hee34, d);
		wr(16'h0900, 1'h1, 16'h0077);
		rd(16'h0900, 1'h0);
		chk("lane_lo", 16'hee77, d);
	endtask

	task automatic t_xy;
		wr(16'h0a00, 1'h0, 16'h0a0a);
		wr(16'h1a00, 1'h0, 16'h0b0b);
		fork
			rd(16'h0a00, 1'h0);
			yrd(16'h1a00, 16'h0b0b);
		join
		chk("x_par", 16'h0a0a, d);
		yrd(16'h0a00, 16'h0000);
	endtask

	task automatic t_map;
		wr(16'h0023, 1'h1, 16'h0077);
		chk("ctrl_wr_en", 1'h1, ctrl_wr_en);
		chk("ctrl_addr", 16'h0023, ctrl_wr_addr);
		chk("ctrl_lanes", 16'h0002, {ctrl_wr_hi, ctrl_wr_lo});
		chk("ctrl_data", 16'h7777, ctrl_wr_data);
		rd(16'h0022, 1'h0);
		chk("ctrl_rd", 16'h7700, d);
		rd(16'h0040, 1'h0);
		chk("ctrl_unused", 16'h0000, d);
		wr(16'h3000, 1'h0, 16'h9999);
		rd(16'h3000, 1'h0);
		chk("unimpl", 16'h0000, d);
		rd(16'h8004, 1'h0);
		chk("psv", 16'h04fb, d);
	endtask

	task automatic t_dma;
		dma(1'h1, 10'h00c, 16'hbeef);
		fork
			rd(16'h2018, 1'h0);
			dma(1'h0, 10'h00c, 16'h0000);
		join
		chk("dma_to_core", 16'hbeef, d);
		chk("dma_rd", 16'hbeef, q);
		yrd(16'h2018, 16'hbeef);
		wr(16'h2012, 1'h0, 16'h3333);
		col(16'h2010, 1'h0, 16'h1111, 10'h008, 16'h2222);
		rd(16'h2010, 1'h0);
		chk("core_wins", 16'h1111, d);
		rd(16'h2012, 1'h0);
		chk("neighbour", 16'h3333, d);
		dma(1'h0, 10'h008, 16'h0000);
		chk("dma_view", 16'h1111, q);
		col(16'h2014, 1'h1, 16'h00aa, 10'h00a, 16'h1234);
		rd(16'h2014, 1'h0);
		chk("lane_wins", 16'h12aa, d);
	endtask

	task automatic t_wreg;
		logic [15:0] e;
		logic [15:0] s;
		for (int j = 0; j < 2; j++) begin
			s = (j == 0) ? 16'h3a85 : 16'h857f;
			for (int k = 0; k < 4; k++) begin
				@(negedge clk_sys);
				wr_req = 1'h1;
				wr_op = dsa_pkg::dsa_wop_t'(k);
				wr_src = s;
				wr_cur = (k < 2) ? 16'hc3c3 : s;
				@(negedge clk_sys);
				wr_req = 1'h0;
				case (k)
					0: e = s;
					1: e = {8'hc3, s[7:0]};
					2: e = {{8{s[7]}}, s[7:0]};
					default: e = {8'h00, s[7:0]};
				endcase
				chk("wr_valid", 1'h1, wr_valid);
				chk("wr_result", e, wr_result);
			end
		end
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		reset = 1'h1;
		{ax_req, ax_byte, ax_write, ax_bitrev_en, ax_mod_en, ay_req, ay_byte, ay_mod_en} = '0;
		{x_rd_en, x_rd_byte, y_rd_en, x_wr_en, x_wr_byte, dma_en, dma_we, wr_req, dma_addr} = '0;
		{ax_source_pointer_register, ax_abs, ay_source_pointer_register, x_rd_addr} = '0;
		{y_rd_addr, x_wr_addr, x_wr_data, dma_wdata, wr_cur, wr_src} = '0;
		ax_mode = dsa_pkg::DSA_IND;
		ay_mode = dsa_pkg::DSA_IND;
		wr_op = dsa_pkg::DSA_LOAD_WORD;
		ax_bitrev_mod = 16'h0008;
		ax_mod_start = 16'h0900;
		ax_mod_end = 16'h090f;
		ay_mod_start = 16'h1800;
		ay_mod_end = 16'h180f;
		repeat (3) @(negedge clk_sys);
		reset = 1'h0;
		t_agu;
		t_mem;
		t_xy;
		t_map;
		t_dma;
		t_wreg;
		wrap_up;
	end

	initial begin
		#100000;
		n_mismatch++;
		wrap_up;
	end
endmodule
